// [verilog/trig_qualify.sv]
// Shared constants and the trigger pin qualifier
package tcc_pkg;
  // ==========================================================
  // Widths and counting modes
  localparam int         CNT_W       = 16;
  localparam logic [1:0] MODE_FREE   = 2'h0; // Free running
  localparam logic [1:0] MODE_MATCH  = 2'h1; // Clear on first match
  localparam logic [1:0] MODE_TRIG   = 2'h2; // Clear on first pin edge
  // ==========================================================
  // Valid edge encodings
  localparam logic [1:0] EDGE_FALL   = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_NONE   = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;
  // ==========================================================
  // Reset values and timing
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam int         QUAL_SAMPLES = 2; // Equal samples to accept
  localparam int         PULSE_EXTRA  = 2; // Extra count periods needed
endpackage : tcc_pkg

// Two-stage synchroniser, double-sample noise filter, edge detector
module trig_qualify
  import tcc_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       srst,       // Sync reset, active high
  input  wire logic       pin,        // Asynchronous trigger pin
  input  wire logic       sample_en,  // Sampling clock strobe
  input  wire logic       enable,     // Timer running
  input  wire logic [1:0] edge_sel,   // Valid edge selection
  output logic            valid_edge  // One-cycle edge pulse
);
  logic sync0_reg, sync1_reg, smp_reg, lvl_reg, edge_reg;
  logic smp_next, lvl_next, edge_next;

  // ==========================================================
  // Synchroniser: only sync1 looks at sync0
  always_ff @(posedge clk) begin
    if (srst) begin
      sync0_reg <= 1'b0;
      sync1_reg <= 1'b0;
    end else begin
      sync0_reg <= pin;
      sync1_reg <= sync0_reg;
    end
  end

  // Level accepted only after two equal samples while enabled; stopped, it follows sync1
  always_comb begin
    smp_next  = smp_reg;
    lvl_next  = lvl_reg;
    edge_next = 1'b0;
    if (!enable) begin
      // Track the pin silently so a restart sees no edge
      smp_next = sync1_reg;
      lvl_next = sync1_reg;
    end else if (sample_en) begin
      smp_next = sync1_reg;
      if (sync1_reg == smp_reg && sync1_reg != lvl_reg) begin
        lvl_next = sync1_reg;
        case (edge_sel)
          EDGE_FALL: edge_next = !sync1_reg;
          EDGE_RISE: edge_next = sync1_reg;
          EDGE_BOTH: edge_next = 1'b1;
          default:   edge_next = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      smp_reg  <= 1'b0;
      lvl_reg  <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      smp_reg  <= smp_next;
      lvl_reg  <= lvl_next;
      edge_reg <= edge_next;
    end
  end

  assign valid_edge = edge_reg;
endmodule : trig_qualify

// [verilog/timer_capture_compare_guards.sv]
// Timer counter with two capture/compare registers and guards
module timer_capture_compare_guards
  import tcc_pkg::*;
(
  input  wire logic             clk,          // 100 MHz system clock
  input  wire logic             srst,         // Sync reset, active high
  input  wire logic             timer_run,    // Timer running level
  input  wire logic [1:0]       count_mode,   // tcc_pkg::MODE_* value
  input  wire logic             count_rise,   // Prescaled clock rise strobe
  input  wire logic             count_fall,   // Prescaled clock fall strobe
  input  wire logic             count_on_pin, // First pin edge is count clock
  input  wire logic [1:0]       edge_first,   // First pin valid edge
  input  wire logic [1:0]       edge_second,  // Second pin valid edge
  input  wire logic [1:0]       cap_mode,     // Per register capture enable
  input  wire logic             first_trigger_pin,  // Async pin
  input  wire logic             second_trigger_pin, // Async pin
  input  wire logic [1:0]       rd_cc,        // Register read strobes
  input  wire logic             rd_cnt,       // Counter read strobe
  input  wire logic [1:0]       wr_cc,        // Compare write strobes
  input  wire logic [CNT_W-1:0] wr_data,      // Compare write data
  output logic [CNT_W-1:0]      rd_data,      // Read data, registered
  output logic [CNT_W-1:0]      main_counter, // Counter value
  output logic [CNT_W-1:0]      first_capture_compare,  // Register 0
  output logic [CNT_W-1:0]      second_capture_compare, // Register 1
  output logic                  first_capture_irq,  // Capture pulse
  output logic                  second_capture_irq  // Capture pulse
);
  import tcc_pkg::*;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_FALL = 3'b010,
    CAP_RISE = 3'b100
  } cap_state_t;

  logic             edge1, edge2, sample1;
  logic [1:0]       cap_trig;
  logic [CNT_W-1:0] cnt_reg, cnt_next, rd_reg, rd_next;
  logic [CNT_W-1:0] cc_reg [2];
  logic [1:0]       cap_latch, irq_reg;

  // ==========================================================
  // Pin qualifiers; pin counting makes the first qualifier sample every cycle
  assign sample1 = count_on_pin ? 1'b1 : count_rise;

  trig_qualify u_q1 (
    .clk        (clk),
    .srst       (srst),
    .pin        (first_trigger_pin),
    .sample_en  (sample1),
    .enable     (timer_run),
    .edge_sel   (edge_first),
    .valid_edge (edge1)
  );

  trig_qualify u_q2 (
    .clk        (clk),
    .srst       (srst),
    .pin        (second_trigger_pin),
    .sample_en  (count_rise),
    .enable     (timer_run),
    .edge_sel   (edge_second),
    .valid_edge (edge2)
  );

  // ==========================================================
  // Capture triggers: register 0 from second pin, 1 from first
  always_comb begin
    cap_trig[0] = timer_run && cap_mode[0] && edge2;
    // First pin edge never captures while it clocks the counter
    cap_trig[1] = timer_run && cap_mode[1] && edge1
                  && !count_on_pin;
  end

  // ==========================================================
  // Counter with free running and two clearing modes
  always_comb begin
    cnt_next = cnt_reg;
    if (timer_run) begin
      if (count_mode == MODE_TRIG && edge1 && !count_on_pin) begin
        cnt_next = CNT_RST;
      end else if (count_on_pin ? edge1 : count_rise) begin
        if (count_mode == MODE_MATCH && cnt_reg == cc_reg[0]) begin
          cnt_next = CNT_RST;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Per-register capture sequencer and storage
  for (genvar i = 0; i < 2; i++) begin : g_cap
    cap_state_t       st_reg, st_next;
    logic [CNT_W-1:0] val_reg, val_next, cc_next;
    logic             irq_next;

    always_comb begin
      st_next   = st_reg;
      val_next  = val_reg;
      cc_next   = cc_reg[i];
      irq_next  = 1'b0;
      cap_latch[i] = 1'b0;
      case (st_reg)
        CAP_IDLE: begin
          if (cap_trig[i]) begin
            val_next = cnt_reg;
            st_next  = CAP_FALL;
          end
        end
        CAP_FALL: begin
          if (count_fall) begin
            cc_next      = val_reg;
            cap_latch[i] = 1'b1;
            st_next      = CAP_RISE;
          end
        end
        CAP_RISE: begin
          if (count_rise) begin
            irq_next = 1'b1;
            st_next  = CAP_IDLE;
          end
        end
        default: st_next = CAP_IDLE;
      endcase
      // Software write only when no capture lands this cycle
      if (wr_cc[i] && !cap_latch[i]) begin
        cc_next = wr_data;
      end
      // Stopping abandons an unfinished capture
      if (!timer_run) begin
        st_next = CAP_IDLE;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        st_reg     <= CAP_IDLE;
        val_reg    <= CNT_RST;
        cc_reg[i]  <= CNT_RST;
        irq_reg[i] <= 1'b0;
      end else begin
        st_reg     <= st_next;
        val_reg    <= val_next;
        cc_reg[i]  <= cc_next;
        irq_reg[i] <= irq_next;
      end
    end
  end

  // ==========================================================
  // Read port; a colliding capture is stored and also returned by the read
  always_comb begin
    rd_next = rd_reg;
    if (rd_cnt) begin
      rd_next = cnt_reg;
    end else if (rd_cc[0]) begin
      rd_next = cap_latch[0] ? g_cap[0].val_reg : cc_reg[0];
    end else if (rd_cc[1]) begin
      rd_next = cap_latch[1] ? g_cap[1].val_reg : cc_reg[1];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_reg <= CNT_RST;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data                = rd_reg;
  assign main_counter           = cnt_reg;
  assign first_capture_compare  = cc_reg[0];
  assign second_capture_compare = cc_reg[1];
  assign first_capture_irq      = irq_reg[0];
  assign second_capture_irq     = irq_reg[1];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_cap_wins_write: assert property (
    cap_latch[0] |=> cc_reg[0] == $past(g_cap[0].val_reg))
    else $error("capture lost to write");
  a_read_no_capture: assert property (
    rd_cnt && !cap_latch[1] && !wr_cc[1] |=> $stable(cc_reg[1]))
    else $error("counter read changed second register");
  a_stopped_no_edge: assert property (
    !timer_run [*3] |-> !edge1 && !edge2)
    else $error("pin edge while stopped");
  a_stopped_counter: assert property (
    !timer_run |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  a_pin_clock_nocap: assert property (
    count_on_pin && g_cap[1].st_reg == CAP_IDLE
      |=> g_cap[1].st_reg == CAP_IDLE)
    else $error("first pin captured while counting");
  a_latch_on_fall: assert property (
    cap_latch[0] |-> count_fall)
    else $error("capture latched off a fall strobe");
  a_irq_after_rise: assert property (
    $rose(irq_reg[1]) |-> $past(count_rise)
      && $past(g_cap[1].st_reg) == CAP_RISE)
    else $error("interrupt not on rise after latch");
  a_irq_one_cycle: assert property (
    first_capture_irq |=> !first_capture_irq)
    else $error("interrupt longer than one cycle");
  a_noise_two_samples: assert property (
    edge2 |-> $past(count_rise)
      && $past(u_q2.sync1_reg) == $past(u_q2.smp_reg))
    else $error("edge without two equal samples");
  a_match_clear: assert property (
    timer_run && count_mode == MODE_MATCH && count_rise
      && !count_on_pin && cnt_reg == cc_reg[0] |=> cnt_reg == CNT_RST)
    else $error("match did not clear counter");

  c_first_capture:  cover property (first_capture_irq);
  c_second_capture: cover property (second_capture_irq);
  c_read_collide:   cover property (rd_cc[0] && cap_latch[0]);
  c_pin_clear:      cover property (count_mode == MODE_TRIG && edge1);
endmodule : timer_capture_compare_guards

// [verification/trig_source.sv]
// External trigger pin source driving both capture pins
module trig_source (
  input  wire logic clk,   // System clock
  output logic      pin_a, // First trigger pin
  output logic      pin_b  // Second trigger pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pins idle low between pulses, never left floating
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // A short len breaks the pulse width rule on purpose
  task automatic pulse(input int w, input int len);
    if (w != 0) pin_b = 1'b1;
    else pin_a = 1'b1;
    repeat (len) @(posedge clk);
    #1;
    pin_a = 1'b0;
    pin_b = 1'b0;
  endtask : pulse
endmodule : trig_source

// [verification/tb.sv]
// Self-checking bench for the capture/compare timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, timer_run = 1'b0;
  logic        count_rise = 1'b0, count_fall = 1'b0, rd_cnt = 1'b0;
  logic        count_on_pin = 1'b0, rd_cc_f = 1'b0, rd_cnt_f = 1'b0;
  logic        rise_d = 1'b0, hit, rr, irq0, irq1, pin_a, pin_b;
  logic [1:0]  count_mode = MODE_FREE, cap_mode = 2'h0;
  logic [1:0]  edge_sec = EDGE_RISE;
  logic [1:0]  rd_cc = 2'h0, wr_cc = 2'h0;
  logic [15:0] wr_data = 16'h0, m_cnt = 16'h0, cmp = 16'h0, m0, held;
  logic [15:0] rd_data, main_counter, cc0, cc1;
  logic [31:0] seed = 32'h830967b1;
  int          n_fail = 0, total_checks = 0, ph = 0;
  always #5 clk = ~clk;
  timer_capture_compare_guards dut (.clk(clk), .srst(srst),
    .timer_run(timer_run), .count_mode(count_mode),
    .count_rise(count_rise), .count_fall(count_fall),
    .count_on_pin(count_on_pin), .edge_first(EDGE_RISE),
    .edge_second(edge_sec), .cap_mode(cap_mode),
    .first_trigger_pin(pin_a), .second_trigger_pin(pin_b),
    .rd_cc(rd_cc), .rd_cnt(rd_cnt), .wr_cc(wr_cc), .wr_data(wr_data),
    .rd_data(rd_data), .main_counter(main_counter),
    .first_capture_compare(cc0), .second_capture_compare(cc1),
    .first_capture_irq(irq0), .second_capture_irq(irq1));
  trig_source p (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] next_cnt(input logic [15:0] c);
    return (count_mode == MODE_MATCH && c == cmp) ? 16'h0 : c + 16'h1;
  endfunction : next_cnt
  // Counter model, then strobes; reads sit on fall cycles so the
  // counter cannot move between the strobe and the answer
  always @(posedge clk) begin
    rise_d <= count_rise;
    if (srst) begin
      m_cnt <= 16'h0;
    end else if (count_rise && timer_run && !count_on_pin) begin
      m_cnt <= next_cnt(m_cnt);
    end
    #1;
    ph = (ph + 1) % 8;
    count_rise = (ph == 0);
    count_fall = (ph == 4);
    rd_cc = {1'b0, rd_cc_f && ph == 4};
    rd_cnt = rd_cnt_f && ph == 4;
  end
  // ==========================================================
  // Compare, drive and closing tasks
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic reset_dut();
    srst = 1'b1;
    timer_run = 1'b0;
    count_on_pin = 1'b0;
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
  endtask : reset_dut
  task automatic wr(input int i, input logic [15:0] v);
    wr_cc[i] = 1'b1;
    wr_data = v;
    @(posedge clk);
    #1 wr_cc = 2'h0;
    // Let an edge pass so a following write never re-raises the strobe
    @(posedge clk);
    #1;
  endtask : wr
  // Irq must follow a count rise and last one cycle
  task automatic wait_irq(input int w);
    hit = 1'b0;
    rr = 1'b0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if ((w != 0 ? irq0 : irq1) === 1'b1) begin
        hit = 1'b1;
        rr = rise_d;
        @(posedge clk);
        #1 rr = rr && ((w != 0 ? irq0 : irq1) === 1'b0);
        break;
      end
    end
  endtask : wait_irq
  // Pulse starts just after a fall; expected capture is two ticks on
  task automatic cap(input int w, input int len);
    @(posedge clk iff count_fall);
    #1 m0 = m_cnt;
    fork
      p.pulse(w, len);
    join_none
    wait_irq(w);
    repeat (64) @(posedge clk);
    #1;
  endtask : cap
  // ==========================================================
  // Scenarios
  initial begin
    reset_dut();
    chk16(main_counter, CNT_RST);
    chk1(irq0, 1'b0);
    for (int m = 0; m < 3; m++) begin
      reset_dut();
      wr(0, 16'h0003);
      cmp = 16'h0003;
      chk16(cc0, 16'h0003);
      for (int k = 0; k < 2; k++) begin
        held = 16'(rnd());
        wr(1, held);
        chk16(cc1, held);
      end
      count_mode = m[1:0]; // No one-shot output requested
      timer_run = 1'b1;
      repeat (90 + rnd() % 16) @(posedge clk);
      #1 chk16(main_counter, m_cnt);
    end
    reset_dut();
    count_mode = MODE_FREE;
    cap_mode = 2'h3;
    timer_run = 1'b1;
    rd_cc_f = 1'b1;
    cap(1, 5);
    chk1(hit, 1'b0);
    chk16(cc0, 16'h0);
    cap(1, 24 + rnd() % 16);
    chk1(hit, 1'b1);
    chk1(rr, 1'b1);
    chk16(cc0, m0 + 16'h2);
    rd_cc_f = 1'b0;
    cap(0, 24 + rnd() % 16);
    chk1(hit, 1'b1);
    chk16(cc1, m0 + 16'h2);
    timer_run = 1'b0;
    held = cc0;
    cap(1, 30);
    chk1(hit, 1'b0);
    cap(0, 30);
    chk1(hit, 1'b0);
    chk16(cc0, held);
    timer_run = 1'b1;
    count_on_pin = 1'b1;
    held = cc1;
    cap(0, 30);
    chk1(hit, 1'b0);
    chk16(cc1, held);
    // Rising pin edge is the count clock: exactly one tick
    chk16(main_counter, m_cnt + 16'h1);
    reset_dut();
    timer_run = 1'b1;
    rd_cnt_f = 1'b1;
    for (int k = 0; k < 6; k++) begin
      repeat (2 + rnd() % 8) @(posedge clk iff count_fall);
      #1 chk16(rd_data, m_cnt);
      chk16(cc1, 16'h0);
    end
    // Falling edge on second pin; valid edge changed only while stopped
    rd_cnt_f = 1'b0;
    timer_run = 1'b0;
    edge_sec = EDGE_FALL;
    @(posedge clk);
    #1 timer_run = 1'b1;
    cap(1, 32);
    chk1(hit, 1'b1);
    // Fall accepted at the sixth tick after the pulse starts
    chk16(cc0, m0 + 16'h6);
    // Pin-clear mode: clear at the edge, nine ticks before the look
    count_mode = MODE_TRIG;
    cap(0, 30);
    chk1(hit, 1'b1);
    chk16(cc1, m0 + 16'h2);
    chk16(main_counter, 16'h0009);
    complete_run();
  end
  // Whole run needs under two thousand cycles
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : tb
